//--- design/fss_params.svh
// Timing counts, sizes and status codes for the fieldbus slave state machine
`ifndef FSS_PARAMS_SVH
`define FSS_PARAMS_SVH

// Clock period and the process-data cycle time, in ns
`define FSS_CLK_NS 5
`define FSS_CYCLE_NS 1000
// Cycles per process-data cycle, rounded down
`define FSS_CYCLE_CYC (`FSS_CYCLE_NS / `FSS_CLK_NS)

// Widths and depths
`define FSS_PD_W 32
`define FSS_MBX_DEPTH 16
`define FSS_CFG_KINDS 6

// Status codes for a state request: none when accepted, else why it was refused
`define FSS_ERR_NONE 8'h00
`define FSS_ERR_SKIP 8'h11
`define FSS_ERR_BADREQ 8'h12

// Configuration kinds, bounds for the two preparation groups
`define FSS_CFG_PREOP_LAST 3'h2
`define FSS_CFG_SAFEOP_FIRST 3'h3
`define FSS_CFG_SAFEOP_LAST 3'h5

`endif

//--- design/fss_pkg.sv
// Types shared by both ends of the fieldbus slave state machine
package fss_pkg;

  // Communication states, one-hot so order compares as magnitude
  typedef enum logic [3:0] {
    FSS_INIT   = 4'h1,
    FSS_PREOP  = 4'h2,
    FSS_SAFEOP = 4'h4,
    FSS_OP     = 4'h8
  } fss_state_t;

  // Configuration steps the master performs over the link
  typedef enum logic [2:0] {
    FSS_CFG_ADDR   = 3'h0,
    FSS_CFG_MBX    = 3'h1,
    FSS_CFG_DCLK   = 3'h2,
    FSS_CFG_MAP    = 3'h3,
    FSS_CFG_SMCH   = 3'h4,
    FSS_CFG_MMU    = 3'h5
  } fss_cfg_t;

  // Master sequencer states
  typedef enum logic [5:0] {
    FSS_H_IDLE = 6'h01,
    FSS_H_STEP = 6'h02,
    FSS_H_CFG  = 6'h04,
    FSS_H_REQ  = 6'h08,
    FSS_H_WAIT = 6'h10,
    FSS_H_MBX  = 6'h20
  } fss_host_st_t;

endpackage

//--- design/fss_link_if.sv
// Link between the network master end and the slave state machine end
`timescale 1ns/1ps
interface fss_link_if #(parameter int PD_W = 32);
  // Master to slave
  logic st_req_valid;
  logic [3:0] st_req;
  logic cfg_valid;
  logic [2:0] cfg_kind;
  logic mbx_valid;
  logic mbx_write;
  logic [15:0] mbx_index;
  logic [31:0] mbx_wdata;
  logic cycle_tick;
  logic rxpd_valid;
  logic [PD_W-1:0] rxpd_data;
  // Slave to master
  logic st_ack;
  logic [3:0] st_cur;
  logic st_err;
  logic [7:0] st_err_code;
  logic mbx_rsp_valid;
  logic mbx_rsp_err;
  logic [31:0] mbx_rsp_data;
  logic txpd_valid;
  logic [PD_W-1:0] txpd_data;

  modport slave (
    input st_req_valid, st_req, cfg_valid, cfg_kind, mbx_valid, mbx_write,
    input mbx_index, mbx_wdata, cycle_tick, rxpd_valid, rxpd_data,
    output st_ack, st_cur, st_err, st_err_code, mbx_rsp_valid, mbx_rsp_err,
    output mbx_rsp_data, txpd_valid, txpd_data
  );
  modport master (
    output st_req_valid, st_req, cfg_valid, cfg_kind, mbx_valid, mbx_write,
    output mbx_index, mbx_wdata, cycle_tick, rxpd_valid, rxpd_data,
    input st_ack, st_cur, st_err, st_err_code, mbx_rsp_valid, mbx_rsp_err,
    input mbx_rsp_data, txpd_valid, txpd_data
  );
endinterface

//--- design/fss_pd_gate.sv
// Registered process-data stage that passes words only while enabled
`timescale 1ns/1ps
module fss_pd_gate #(
  parameter int W = 32
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  output logic [W-1:0] out_data
);

  initial
  begin
    if (W < 1)
      $error("fss_pd_gate: W must be at least 1");
  end

  // A disabled stage keeps its last word but never marks it valid
  wire take = enable & in_valid;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else
    begin
      out_valid <= take;
      if (take)
        out_data <= in_data;
    end
  end

endmodule

//--- design/fss_slave_end.sv
// Slave end: communication state machine and service gating of a drive
// Function
// R1: Four states, reported, following master requests
// R2: Upward moves go one state at a time
// R3: Downward requests may skip states
// R4: Init offers no mailbox nor process data
// R5: Master configures address, mailbox, clock first
// R6: Pre-operational serves mailbox only
// R7: Master prepares mapping, channels, units first
// R8: Safe-operational: mailbox, transmit data, clock
// R9: Master sends output data before operational
// R10: Operational: both data directions, mailbox too
// R11: Cyclic process data, acyclic parameter access
// R12: Skipping upward request refused, error raised
`timescale 1ns/1ps
`include "fss_params.svh"
module fss_slave_end
  import fss_pkg::*;
#(
  parameter int PD_W = `FSS_PD_W,
  parameter int MBX_DEPTH = `FSS_MBX_DEPTH
) (
  input wire logic clock,
  input wire logic sys_rst,
  fss_link_if.slave link,
  input wire logic [PD_W-1:0] in_pd_data,
  output logic out_pd_valid,
  output logic [PD_W-1:0] out_pd_data,
  output logic [3:0] app_state,
  output logic [5:0] cfg_done,
  output logic dclk_enable,
  output logic mbx_busy_err
);

  localparam int IDX_W = $clog2(MBX_DEPTH);

  initial
  begin
    if (MBX_DEPTH < 2 || (MBX_DEPTH & (MBX_DEPTH - 1)) != 0)
      $error("fss_slave_end: MBX_DEPTH must be a power of two >= 2");
    if (PD_W < 1)
      $error("fss_slave_end: PD_W must be at least 1");
  end

  fss_state_t cur_reg;
  fss_state_t cur_next;
  logic ack_reg;
  logic err_reg;
  logic err_next;
  logic [7:0] code_reg;
  logic [7:0] code_next;
  logic [5:0] cfg_reg;
  logic [5:0] cfg_next;
  logic rsp_valid_reg;
  logic rsp_err_reg;
  logic [31:0] rsp_data_reg;
  logic [31:0] mbx_mem [MBX_DEPTH];
  logic dclk_reg;
  logic mbx_err_reg;

  // Request decode
  wire [3:0] req = link.st_req;
  wire req_known = (req == FSS_INIT) | (req == FSS_PREOP) |
                   (req == FSS_SAFEOP) | (req == FSS_OP);
  wire req_up = req > cur_reg;
  wire [3:0] one_up = {cur_reg[2:0], 1'b0};
  wire req_step = req == one_up;
  // R2, R12: an upward request must name the very next state
  wire req_skip = req_known & req_up & ~req_step; // R12
  // R3: any lower known state is taken directly
  wire req_ok = req_known & ~req_skip; // R3

  // Services allowed in each state
  wire in_init = cur_reg == FSS_INIT; // R4
  wire mbx_on = ~in_init; // R6
  wire txpd_on = (cur_reg == FSS_SAFEOP) | (cur_reg == FSS_OP); // R8
  wire rxpd_on = cur_reg == FSS_OP; // R10

  // Mailbox access decode
  wire [IDX_W-1:0] mbx_idx = link.mbx_index[IDX_W-1:0];
  wire mbx_take = link.mbx_valid & mbx_on; // R6
  wire mbx_refuse = link.mbx_valid & ~mbx_on; // R4

  // State transition and error flag
  always_comb
  begin
    cur_next = cur_reg;
    err_next = err_reg;
    code_next = code_reg;
    if (link.st_req_valid)
    begin
      if (!req_known)
      begin
        err_next = 1'b1;
        code_next = `FSS_ERR_BADREQ;
      end
      else if (req_skip)
      begin
        err_next = 1'b1; // R12
        code_next = `FSS_ERR_SKIP; // R12
      end
      else if (req_ok)
      begin
        cur_next = fss_state_t'(req); // R1
        err_next = 1'b0;
        code_next = `FSS_ERR_NONE;
      end
    end
  end

  // Configuration record; an accepted request for init clears it, save a step noted in the same cycle
  always_comb
  begin
    cfg_next = cfg_reg;
    if (link.st_req_valid && req_ok && req == FSS_INIT)
      cfg_next = '0;
    if (link.cfg_valid && link.cfg_kind < 3'(`FSS_CFG_KINDS))
      cfg_next[link.cfg_kind] = 1'b1;
  end

  // Every request gets one acknowledge, refused or not
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      cur_reg <= FSS_INIT;
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      code_reg <= `FSS_ERR_NONE;
      cfg_reg <= '0;
    end
    else
    begin
      cur_reg <= cur_next; // R1
      ack_reg <= link.st_req_valid;
      err_reg <= err_next;
      code_reg <= code_next;
      cfg_reg <= cfg_next;
    end
  end

  // Mailbox parameter store, acyclic access only
  always_ff @(posedge clock)
  begin
    if (mbx_take && link.mbx_write)
      mbx_mem[mbx_idx] <= link.mbx_wdata; // R11
  end

  // Mailbox answer one cycle after the request
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rsp_valid_reg <= 1'b0;
      rsp_err_reg <= 1'b0;
      rsp_data_reg <= '0;
      mbx_err_reg <= 1'b0;
    end
    else
    begin
      rsp_valid_reg <= link.mbx_valid;
      rsp_err_reg <= mbx_refuse; // R4
      mbx_err_reg <= mbx_refuse;
      if (mbx_take && !link.mbx_write)
        rsp_data_reg <= mbx_mem[mbx_idx]; // R6
      else
        rsp_data_reg <= '0;
    end
  end

  // Clock sync only once configured and past pre-operational
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      dclk_reg <= 1'b0;
    else
      dclk_reg <= txpd_on & cfg_reg[FSS_CFG_DCLK]; // R8
  end

  // Received output data reaches the drive only when operational
  fss_pd_gate #(.W(PD_W)) u_rx_gate (
    .clock(clock),
    .sys_rst(sys_rst),
    .enable(rxpd_on), // R10
    .in_valid(link.rxpd_valid),
    .in_data(link.rxpd_data),
    .out_valid(out_pd_valid),
    .out_data(out_pd_data)
  );

  // Transmitted input data once per cycle tick, safe-op and up
  fss_pd_gate #(.W(PD_W)) u_tx_gate (
    .clock(clock),
    .sys_rst(sys_rst),
    .enable(txpd_on), // R8
    .in_valid(link.cycle_tick), // R11
    .in_data(in_pd_data),
    .out_valid(link.txpd_valid),
    .out_data(link.txpd_data)
  );

  // Link and user outputs, all straight from flops
  assign link.st_ack = ack_reg;
  assign link.st_cur = cur_reg; // R1
  assign link.st_err = err_reg; // R12
  assign link.st_err_code = code_reg;
  assign link.mbx_rsp_valid = rsp_valid_reg;
  assign link.mbx_rsp_err = rsp_err_reg;
  assign link.mbx_rsp_data = rsp_data_reg;
  assign app_state = cur_reg;
  assign cfg_done = cfg_reg;
  assign dclk_enable = dclk_reg;
  assign mbx_busy_err = mbx_err_reg;

endmodule

//--- design/fss_master_end.sv
// Master end: walks the slave through its states and drives cyclic data
`timescale 1ns/1ps
`include "fss_params.svh"
module fss_master_end
  import fss_pkg::*;
#(
  parameter int PD_W = `FSS_PD_W,
  parameter int CYCLE_CYC = `FSS_CYCLE_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  fss_link_if.master link,
  input wire logic go,
  input wire logic [3:0] target_state,
  input wire logic u_mbx_valid,
  input wire logic u_mbx_write,
  input wire logic [15:0] u_mbx_index,
  input wire logic [31:0] u_mbx_wdata,
  input wire logic [PD_W-1:0] out_pd_data,
  output logic busy,
  output logic done,
  output logic err,
  output logic [3:0] slave_state,
  output logic u_mbx_done,
  output logic u_mbx_err,
  output logic [31:0] u_mbx_rdata,
  output logic in_pd_valid,
  output logic [PD_W-1:0] in_pd_data
);

  initial
  begin
    if (CYCLE_CYC < 2 || CYCLE_CYC > 65535)
      $error("fss_master_end: CYCLE_CYC out of range");
  end

  fss_host_st_t st_reg;
  logic [3:0] tgt_reg, cur_reg;
  logic [2:0] cfg_idx_reg, cfg_last_reg;
  logic [15:0] cyc_reg;
  logic tick_reg, pd_sent_reg, done_reg, err_reg;
  logic req_v_reg, cfg_v_reg, mbx_v_reg, mbx_w_reg;
  logic [3:0] req_reg;
  logic [15:0] mbx_i_reg;
  logic [31:0] mbx_d_reg, rdata_reg;
  logic rsp_done_reg, rsp_err_reg;
  logic busy_reg;
  logic [2:0] cfg_kind_reg;
  logic rxv_reg, inv_reg;
  logic [PD_W-1:0] rxd_reg, ind_reg;

  // Step decisions; upward always one state, downward direct
  wire [3:0] one_up = {cur_reg[2:0], 1'b0};
  wire at_tgt = cur_reg == tgt_reg;
  wire go_down = tgt_reg < cur_reg;
  wire pd_run = (cur_reg == FSS_SAFEOP) | (cur_reg == FSS_OP);
  wire cyc_end = cyc_reg == 16'(CYCLE_CYC - 1);

  // Cycle timer, free running
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      cyc_reg <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      cyc_reg <= cyc_end ? 16'h0000 : cyc_reg + 16'h0001;
      tick_reg <= cyc_end;
    end
  end

  // Output data sent each tick once the slave runs process data
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rxv_reg <= 1'b0;
      rxd_reg <= '0;
      pd_sent_reg <= 1'b0;
      inv_reg <= 1'b0;
      ind_reg <= '0;
    end
    else
    begin
      rxv_reg <= cyc_end & pd_run; // R11
      if (cyc_end && pd_run)
        rxd_reg <= out_pd_data;
      pd_sent_reg <= pd_run & (pd_sent_reg | rxv_reg); // R9
      inv_reg <= link.txpd_valid;
      if (link.txpd_valid)
        ind_reg <= link.txpd_data;
    end
  end

  // Sequencer
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      st_reg <= FSS_H_IDLE;
      tgt_reg <= FSS_INIT;
      cur_reg <= FSS_INIT;
      cfg_idx_reg <= 3'h0;
      cfg_last_reg <= 3'h0;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      req_v_reg <= 1'b0;
      req_reg <= FSS_INIT;
      cfg_v_reg <= 1'b0;
      mbx_v_reg <= 1'b0;
      mbx_w_reg <= 1'b0;
      mbx_i_reg <= '0;
      mbx_d_reg <= '0;
      rsp_done_reg <= 1'b0;
      rsp_err_reg <= 1'b0;
      rdata_reg <= '0;
      busy_reg <= 1'b0;
      cfg_kind_reg <= 3'h0;
    end
    else
    begin
      done_reg <= 1'b0;
      req_v_reg <= 1'b0;
      cfg_v_reg <= 1'b0;
      mbx_v_reg <= 1'b0;
      rsp_done_reg <= 1'b0;
      case (st_reg)
        FSS_H_IDLE:
        begin
          if (go)
          begin
            tgt_reg <= target_state;
            busy_reg <= 1'b1;
            err_reg <= 1'b0;
            st_reg <= FSS_H_STEP;
          end
          else if (u_mbx_valid)
          begin
            mbx_v_reg <= 1'b1; // R11
            mbx_w_reg <= u_mbx_write;
            mbx_i_reg <= u_mbx_index;
            mbx_d_reg <= u_mbx_wdata;
            busy_reg <= 1'b1;
            st_reg <= FSS_H_MBX;
          end
        end
        FSS_H_STEP:
        begin
          if (at_tgt)
          begin
            done_reg <= 1'b1;
            busy_reg <= 1'b0;
            st_reg <= FSS_H_IDLE;
          end
          else if (go_down)
          begin
            req_reg <= tgt_reg;
            st_reg <= FSS_H_REQ;
          end
          else
          begin
            req_reg <= one_up; // R2
            if (one_up == FSS_PREOP)
            begin
              cfg_idx_reg <= FSS_CFG_ADDR; // R5
              cfg_last_reg <= `FSS_CFG_PREOP_LAST;
              st_reg <= FSS_H_CFG;
            end
            else if (one_up == FSS_SAFEOP)
            begin
              cfg_idx_reg <= `FSS_CFG_SAFEOP_FIRST; // R7
              cfg_last_reg <= `FSS_CFG_SAFEOP_LAST;
              st_reg <= FSS_H_CFG;
            end
            else if (pd_sent_reg)
              st_reg <= FSS_H_REQ; // R9
          end
        end
        FSS_H_CFG:
        begin
          cfg_v_reg <= 1'b1;
          cfg_idx_reg <= cfg_idx_reg + 3'h1;
          cfg_kind_reg <= cfg_idx_reg;
          if (cfg_idx_reg == cfg_last_reg)
            st_reg <= FSS_H_REQ;
        end
        FSS_H_REQ:
        begin
          req_v_reg <= 1'b1;
          st_reg <= FSS_H_WAIT;
        end
        FSS_H_WAIT:
        begin
          if (link.st_ack)
          begin
            cur_reg <= link.st_cur;
            if (link.st_err)
            begin
              err_reg <= 1'b1;
              done_reg <= 1'b1;
              busy_reg <= 1'b0;
              st_reg <= FSS_H_IDLE;
            end
            else
              st_reg <= FSS_H_STEP;
          end
        end
        FSS_H_MBX:
        begin
          if (link.mbx_rsp_valid)
          begin
            rsp_done_reg <= 1'b1;
            rsp_err_reg <= link.mbx_rsp_err;
            rdata_reg <= link.mbx_rsp_data;
            busy_reg <= 1'b0;
            st_reg <= FSS_H_IDLE;
          end
        end
        default:
        begin
          st_reg <= FSS_H_IDLE;
          busy_reg <= 1'b0;
        end
      endcase
    end
  end

  // Link drive; config kind kept in a flop so no adder sits on the link
  assign link.st_req_valid = req_v_reg;
  assign link.st_req = req_reg;
  assign link.cfg_valid = cfg_v_reg;
  assign link.cfg_kind = cfg_kind_reg;
  assign link.mbx_valid = mbx_v_reg;
  assign link.mbx_write = mbx_w_reg;
  assign link.mbx_index = mbx_i_reg;
  assign link.mbx_wdata = mbx_d_reg;
  assign link.cycle_tick = tick_reg;
  assign link.rxpd_valid = rxv_reg;
  assign link.rxpd_data = rxd_reg;

  // User side
  assign busy = busy_reg;
  assign done = done_reg;
  assign err = err_reg;
  assign slave_state = cur_reg;
  assign u_mbx_done = rsp_done_reg;
  assign u_mbx_err = rsp_err_reg;
  assign u_mbx_rdata = rdata_reg;
  assign in_pd_valid = inv_reg;
  assign in_pd_data = ind_reg;

endmodule

//--- sim/fss_link_chk.sv
// Concurrent checks on the link between the master end and the slave end
`timescale 1ns/1ps
module fss_link_chk
  import fss_pkg::*;
#(
  parameter int CYC = 8
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic st_req_valid,
  input wire logic [3:0] st_req,
  input wire logic st_ack,
  input wire logic [3:0] st_cur,
  input wire logic st_err,
  input wire logic mbx_valid,
  input wire logic mbx_rsp_valid,
  input wire logic mbx_rsp_err,
  input wire logic [31:0] mbx_rsp_data,
  input wire logic cycle_tick,
  input wire logic txpd_valid
);
  // One domain, so clock and disable are given once
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  // State request handshake and state movement
  a_ack_after_req: assert property (st_req_valid |=> st_ack)
    else $error("state request not acknowledged next cycle");
  a_ack_only_req: assert property (st_ack |-> $past(st_req_valid))
    else $error("acknowledge without a request");
  a_state_holds: assert property (!$past(st_req_valid) |-> $stable(st_cur))
    else $error("state moved without a request");
  a_up_one_step: assert property (st_ack && (st_cur > $past(st_cur))
    |-> st_cur == ($past(st_cur) << 1))
    else $error("upward move skipped a state");
  a_down_skip: assert property (st_req_valid && $onehot(st_req) && (st_req < st_cur)
    |=> (st_cur == $past(st_req)) && !st_err)
    else $error("downward request not taken directly");

  // Mailbox service by state; the answer always comes one cycle later
  a_mbx_latency: assert property (mbx_valid |=> mbx_rsp_valid)
    else $error("mailbox answer not one cycle later");
  a_init_refused: assert property (mbx_valid && st_cur == FSS_INIT
    |=> mbx_rsp_err && mbx_rsp_data == 32'h0)
    else $error("mailbox served in init");
  a_mbx_ok_run: assert property (mbx_valid && st_cur != FSS_INIT |=> !mbx_rsp_err)
    else $error("mailbox refused outside init");

  // Transmitted process data follows the tick only in the running states
  a_tx_in_run: assert property (cycle_tick && (st_cur == FSS_SAFEOP || st_cur == FSS_OP)
    |=> txpd_valid)
    else $error("no transmit data after tick");
  a_tx_silent: assert property (txpd_valid |-> $past(cycle_tick)
    && $past(st_cur) != FSS_INIT && $past(st_cur) != FSS_PREOP)
    else $error("transmit data outside running states");
  a_tick_period: assert property (cycle_tick |-> ##[CYC:CYC] cycle_tick)
    else $error("process data cycle has wrong period");
endmodule

//--- sim/test_fieldbus_slave_state_machine.sv
// Bench: master end against slave end, plus a slave driven directly
`timescale 1ns/1ps
module test_fieldbus_slave_state_machine
  import fss_pkg::*;
;
  logic clock, sys_rst, go, u_mbx_valid, u_mbx_write;
  logic [3:0] target_state, m_state, s1_app, s2_app;
  logic [15:0] u_mbx_index;
  logic [31:0] u_mbx_wdata, m_out_pd, s1_in_pd, s2_in_pd, m_rdata, m_in_data, s1_out, s2_out, rnd;
  logic m_busy, m_done, m_err, m_mdone, m_merr, m_in_valid, s1_ov, s2_ov;
  logic s1_dclk, s2_dclk, s1_berr, s2_berr;
  logic [5:0] s1_cfg, s2_cfg;
  logic [12:0] q_st[$];
  logic [32:0] q_mb[$], q_um[$];
  logic [31:0] q_tx[$], q_rx[$];
  logic [13:0] q_done[$];
  logic [12:0] e_st;
  logic [32:0] e_mb;
  logic [13:0] e_dn;
  int num_errors = 0;
  int n_checks = 0;
  int rx1_seen = 0;

  fss_link_if #(.PD_W(32)) link1();
  fss_link_if #(.PD_W(32)) link2();
  fss_master_end #(.PD_W(32), .CYCLE_CYC(8)) fss_master_end_inst (.clock(clock),
    .sys_rst(sys_rst), .link(link1), .go(go), .target_state(target_state),
    .u_mbx_valid(u_mbx_valid), .u_mbx_write(u_mbx_write), .u_mbx_index(u_mbx_index),
    .u_mbx_wdata(u_mbx_wdata), .out_pd_data(m_out_pd), .busy(m_busy), .done(m_done),
    .err(m_err), .slave_state(m_state), .u_mbx_done(m_mdone), .u_mbx_err(m_merr),
    .u_mbx_rdata(m_rdata), .in_pd_valid(m_in_valid), .in_pd_data(m_in_data));
  fss_slave_end fss_slave_end_inst (.clock(clock), .sys_rst(sys_rst), .link(link1),
    .in_pd_data(s1_in_pd), .out_pd_valid(s1_ov), .out_pd_data(s1_out), .app_state(s1_app),
    .cfg_done(s1_cfg), .dclk_enable(s1_dclk), .mbx_busy_err(s1_berr));
  // Second slave faces the bench, which may break the master's rules
  fss_slave_end fss_slave_end_inst2 (.clock(clock), .sys_rst(sys_rst), .link(link2),
    .in_pd_data(s2_in_pd), .out_pd_valid(s2_ov), .out_pd_data(s2_out), .app_state(s2_app),
    .cfg_done(s2_cfg), .dclk_enable(s2_dclk), .mbx_busy_err(s2_berr));
  fss_link_chk #(.CYC(8)) fss_link_chk_inst (.clock(clock), .sys_rst(sys_rst),
    .st_req_valid(link1.st_req_valid), .st_req(link1.st_req), .st_ack(link1.st_ack),
    .st_cur(link1.st_cur), .st_err(link1.st_err), .mbx_valid(link1.mbx_valid),
    .mbx_rsp_valid(link1.mbx_rsp_valid), .mbx_rsp_err(link1.mbx_rsp_err),
    .mbx_rsp_data(link1.mbx_rsp_data), .cycle_tick(link1.cycle_tick),
    .txpd_valid(link1.txpd_valid));

  always #2.5 clock = ~clock;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic stop_test();
    if (num_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bench-driven link: one-cycle request pulses, expectations queued first
  task automatic sreq(input logic [3:0] r, input logic [12:0] e);
    @(posedge clock);
    link2.st_req_valid <= 1'b1;
    link2.st_req <= r;
    q_st.push_back(e);
    @(posedge clock);
    link2.st_req_valid <= 1'b0;
  endtask

  task automatic smbx(input logic w, input logic [15:0] i, input logic [31:0] d,
    input logic [32:0] e);
    @(posedge clock);
    link2.mbx_valid <= 1'b1;
    link2.mbx_write <= w;
    link2.mbx_index <= i;
    link2.mbx_wdata <= d;
    q_mb.push_back(e);
    @(posedge clock);
    link2.mbx_valid <= 1'b0;
    link2.mbx_wdata <= ~d; // Released data never keeps its last value
  endtask

  task automatic scfg(input logic [2:0] k);
    @(posedge clock);
    link2.cfg_valid <= 1'b1;
    link2.cfg_kind <= k;
    @(posedge clock);
    link2.cfg_valid <= 1'b0;
  endtask

  // Tick and output data together; flags say which results the state allows
  task automatic spd(input logic [31:0] d, input logic etx, input logic erx);
    @(posedge clock);
    link2.cycle_tick <= 1'b1;
    link2.rxpd_valid <= 1'b1;
    link2.rxpd_data <= ~d;
    s2_in_pd <= d;
    if (etx) q_tx.push_back(d);
    if (erx) q_rx.push_back(~d);
    @(posedge clock);
    link2.cycle_tick <= 1'b0;
    link2.rxpd_valid <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  // User side of the master end; completion waited for under a bound
  task automatic go_to(input logic [3:0] t, input logic [5:0] cfg);
    int n;
    n = 0;
    @(posedge clock);
    go <= 1'b1;
    target_state <= t;
    q_done.push_back({t, 1'b0, 3'h0, cfg});
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
    chk(64'h1, m_busy);
    while (m_done !== 1'b1 && n < 600)
    begin
      @(posedge clock);
      n++;
    end
    if (n >= 600) chk(64'h1, 64'h0);
    @(posedge clock);
  endtask

  task automatic um(input logic w, input logic [15:0] i, input logic [31:0] d,
    input logic [32:0] e);
    int n;
    n = 0;
    @(posedge clock);
    u_mbx_valid <= 1'b1;
    u_mbx_write <= w;
    u_mbx_index <= i;
    u_mbx_wdata <= d;
    q_um.push_back(e);
    @(posedge clock);
    u_mbx_valid <= 1'b0;
    while (m_mdone !== 1'b1 && n < 100)
    begin
      @(posedge clock);
      n++;
    end
    if (n >= 100) chk(64'h1, 64'h0);
    @(posedge clock);
  endtask

  // Result watcher: each queued result takes the oldest note, none left means a stray one; master-end process data is checked against live values
  always @(posedge clock)
  begin
    if (link2.st_ack === 1'b1)
    begin
      e_st = q_st.size() ? q_st.pop_front() : 'x;
      chk({e_st[12:9], e_st}, {s2_app, link2.st_cur, link2.st_err, link2.st_err_code});
    end
    if (link2.mbx_rsp_valid === 1'b1)
    begin
      e_mb = q_mb.size() ? q_mb.pop_front() : 'x;
      chk({e_mb[32], e_mb}, {s2_berr, link2.mbx_rsp_err, link2.mbx_rsp_data});
    end
    if (link2.txpd_valid === 1'b1) chk(q_tx.size() ? q_tx.pop_front() : 'x,
      link2.txpd_data);
    if (s2_ov === 1'b1) chk(q_rx.size() ? q_rx.pop_front() : 'x, s2_out);
    if (m_done === 1'b1)
    begin
      e_dn = q_done.size() ? q_done.pop_front() : 'x;
      chk({e_dn[13:10], e_dn}, {s1_app, m_state, m_err, m_busy, 2'h0, s1_cfg});
    end
    if (m_mdone === 1'b1) chk(q_um.size() ? q_um.pop_front() : 'x,
      {m_merr, m_rdata});
    if (m_in_valid === 1'b1) chk(s1_in_pd, m_in_data);
    if (s1_ov === 1'b1)
    begin
      rx1_seen++;
      chk(m_out_pd, s1_out);
    end
  end

  initial
  begin
    #100000;
    num_errors++;
    stop_test();
  end

  initial
  begin
    clock = 1'b0;
    sys_rst = 1'b1;
    go = 1'b0;
    target_state = FSS_INIT;
    u_mbx_valid = 1'b0;
    u_mbx_write = 1'b0;
    u_mbx_index = 16'h0;
    u_mbx_wdata = 32'h0;
    rnd = lfsr(32'hf377);
    m_out_pd = rnd;
    s1_in_pd = ~rnd;
    s2_in_pd = 32'h0;
    link2.st_req_valid = 1'b0;
    link2.st_req = FSS_INIT;
    link2.cfg_valid = 1'b0;
    link2.cfg_kind = 3'h0;
    link2.mbx_valid = 1'b0;
    link2.mbx_write = 1'b0;
    link2.mbx_index = 16'h0;
    link2.mbx_wdata = 32'h0;
    link2.cycle_tick = 1'b0;
    link2.rxpd_valid = 1'b0;
    link2.rxpd_data = 32'h0;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    // Bench-driven slave: refusals in init, then up one step at a time
    rnd = lfsr(rnd);
    smbx(1'b1, 16'h0003, rnd, {1'b1, 32'h0});
    sreq(FSS_SAFEOP, {FSS_INIT, 1'b1, 8'h11});
    sreq(FSS_OP, {FSS_INIT, 1'b1, 8'h11});
    sreq(4'h3, {FSS_INIT, 1'b1, 8'h12});
    spd(rnd, 1'b0, 1'b0);
    for (int k = 0; k < 3; k++) scfg(k[2:0]);
    sreq(FSS_PREOP, {FSS_PREOP, 1'b0, 8'h00});
    smbx(1'b1, 16'h0003, rnd, {1'b0, 32'h0});
    smbx(1'b0, 16'h0013, 32'h0, {1'b0, rnd});
    spd(lfsr(rnd), 1'b0, 1'b0);
    sreq(FSS_OP, {FSS_PREOP, 1'b1, 8'h11});
    for (int k = 3; k < 6; k++) scfg(k[2:0]);
    sreq(FSS_SAFEOP, {FSS_SAFEOP, 1'b0, 8'h00});
    sreq(FSS_SAFEOP, {FSS_SAFEOP, 1'b0, 8'h00});
    @(negedge clock);
    chk(64'h1, s2_dclk);
    rnd = lfsr(rnd);
    spd(rnd, 1'b1, 1'b0);
    sreq(FSS_OP, {FSS_OP, 1'b0, 8'h00});
    rnd = lfsr(rnd);
    spd(rnd, 1'b1, 1'b1);
    smbx(1'b0, 16'h0003, 32'h0, {1'b0, lfsr(lfsr(32'hf377))});
    sreq(FSS_INIT, {FSS_INIT, 1'b0, 8'h00});
    @(negedge clock);
    chk(64'h0, s2_cfg);
    // Master end against the slave end
    rnd = lfsr(rnd);
    um(1'b1, 16'h0005, rnd, {1'b1, 32'h0});
    go_to(FSS_PREOP, 6'h07);
    um(1'b1, 16'h0005, rnd, {1'b0, 32'h0});
    um(1'b0, 16'h0005, 32'h0, {1'b0, rnd});
    go_to(FSS_OP, 6'h3f);
    repeat (40) @(posedge clock);
    chk(64'h3, {s1_dclk, rx1_seen != 0});
    go_to(FSS_INIT, 6'h00);
    // Every noted result must have appeared by now
    chk(64'h0, q_st.size() + q_mb.size() + q_tx.size() + q_rx.size()
      + q_done.size() + q_um.size());
    stop_test();
  end
endmodule
